// ===== hdl/hphs_pkg.sv
// Package of constants for the parallel host port pin handshake block
// Behaviour
// - Strobe low with select high: device drives data lines with its read data.
// - Strobe low with select low: data lines stay inputs, host write accepted.
// - Host write data captured on the rising edge of the strobe.
// - Data moves only while the host holds the strobe low, or holds acknowledge low during a request.
// - Service request is open-drain: pulls low to request, else released.
// - Acknowledge input serves as DMA handshake and interrupt acknowledge.
// - Host port not selected: the four handshake pins become port B general I/O.
// - After reset those four general I/O pins are inputs.
// - Request pin as general I/O is push-pull, not open-drain.
// - The host data bus is eight bits wide.
// - Host mode with strobe high and no acknowledged request: all data lines released.
// - Acknowledge low during an active request: device drives the data lines.
package hphs_pkg;
	localparam int HPHS_DATA_W  = 8;
	localparam int HPHS_SEL_W   = 3;
	localparam int HPHS_GPIO_W  = 4;
	localparam int HPHS_FIFO_D  = 8;
	// General I/O bit positions of the four shared pins
	localparam int HPHS_B_DIR   = 0;
	localparam int HPHS_B_STB   = 1;
	localparam int HPHS_B_REQ   = 2;
	localparam int HPHS_B_ACK   = 3;
	localparam logic [3:0] HPHS_GPIO_DIR_RST = 4'h0;
	localparam logic [7:0] HPHS_DATA_RST     = 8'h00;
endpackage

// ===== hdl/hphs_top.sv
// Parallel host port pin handshake with write FIFO and general I/O fallback
`timescale 1ns/100ps
module hphs_fifo
	import hphs_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("FIFO depth must be a power of two of at least two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	wire              full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	wire              empty = (wr_ptr == rd_ptr);
	wire              push  = in_valid && !full;
	wire              pop   = out_ready && !empty;
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rd_ptr[AW-1:0]];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
	// Storage has no reset so it can map onto plain RAM
	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end
endmodule // hphs_fifo

module hphs_top
	import hphs_pkg::*;
#(
	parameter int DATA_W = HPHS_DATA_W,
	parameter int DEPTH  = HPHS_FIFO_D
) (
	input  wire logic              REF_CLK_IN,
	input  wire logic              RST_B_IN,
	input  wire logic              HOST_PORT_SEL_IN,
	input  wire logic              HOST_DIR_SELECT_IN,
	input  wire logic              HOST_TRANSFER_STROBE_N_IN,
	input  wire logic              HOST_ACKNOWLEDGE_N_IN,
	input  wire logic [HPHS_SEL_W-1:0] HOST_REG_SELECT_IN,
	input  wire logic [DATA_W-1:0] HOST_DATA_LINES_IN,
	output logic      [DATA_W-1:0] HOST_DATA_LINES_OUT,
	output logic                   HOST_DATA_LINES_OE_OUT,
	output logic                   HOST_SERVICE_REQUEST_N_OUT,
	output logic                   HOST_SERVICE_REQUEST_N_OE_OUT,
	input  wire logic [DATA_W-1:0] RD_DATA_IN,
	input  wire logic              SERVICE_REQ_IN,
	output logic                   WR_VALID_OUT,
	input  wire logic              WR_READY_IN,
	output logic      [DATA_W-1:0] WR_DATA_OUT,
	output logic [HPHS_SEL_W-1:0]  WR_REG_OUT,
	output logic                   WR_DROP_OUT,
	output logic                   ACK_PULSE_OUT,
	output logic                   RD_DONE_OUT,
	output logic [HPHS_GPIO_W-1:0] GPIO_IN_OUT,
	input  wire logic [HPHS_GPIO_W-1:0] GPIO_DIR_IN,
	input  wire logic [HPHS_GPIO_W-1:0] GPIO_DATA_IN,
	output logic                   GPIO_DIR_OUT_OE,
	output logic                   GPIO_STB_OUT_OE,
	output logic                   GPIO_ACK_OUT_OE
);
	initial begin
		if (DATA_W != HPHS_DATA_W)
			$error("Host data bus must be eight bits");
	end

	logic       rst_s1;
	logic       rst_n;
	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// Pins pass two flops; only the second stage is read
	localparam int NS = 4 + DATA_W + HPHS_SEL_W;
	logic [NS-1:0] s1;
	logic [NS-1:0] s2;
	logic          stb_d;
	logic          ack_d;
	wire  [NS-1:0] pin_raw = {HOST_PORT_SEL_IN, HOST_DIR_SELECT_IN, HOST_TRANSFER_STROBE_N_IN,
		HOST_ACKNOWLEDGE_N_IN, HOST_REG_SELECT_IN, HOST_DATA_LINES_IN};
	always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			s1    <= {4'hB, {(NS-4){1'b0}}};
			s2    <= {4'hB, {(NS-4){1'b0}}};
			stb_d <= 1'b1;
			ack_d <= 1'b1;
		end else begin
			s1    <= pin_raw;
			s2    <= s1;
			stb_d <= s2[NS-3];
			ack_d <= s2[NS-4];
		end
	end
	wire              host_mode = s2[NS-1];
	wire              dir_s     = s2[NS-2];
	wire              stb_n_s   = s2[NS-3];
	wire              ack_n_s   = s2[NS-4];
	wire [HPHS_SEL_W-1:0] sel_s = s2[DATA_W +: HPHS_SEL_W];
	wire [DATA_W-1:0] data_s    = s2[DATA_W-1:0];
	// Edges of the synchronised strobe and acknowledge; data settles with them through the same stages
	wire stb_rise  = host_mode && stb_n_s && !stb_d;
	wire ack_fall  = host_mode && !ack_n_s && ack_d;
	// Direction is only sampled during the strobe, so a steady select is relied on
	wire wr_take   = stb_rise && !dir_s;
	wire rd_done   = stb_rise && dir_s;
	wire req_act   = host_mode && SERVICE_REQ_IN;
	wire drive_rd  = host_mode && ((!stb_n_s && dir_s) || (!ack_n_s && req_act));

	// Output stage loads whenever it is empty or being taken
	wire              stage_free = !WR_VALID_OUT || WR_READY_IN;
	logic             f_in_ready;
	logic             f_out_valid;
	logic [DATA_W+HPHS_SEL_W-1:0] f_out_data;
	hphs_fifo #(.WIDTH(DATA_W + HPHS_SEL_W), .DEPTH(DEPTH)) u_fifo (
		.clk       (REF_CLK_IN),
		.rst_n     (rst_n),
		.in_valid  (wr_take),
		.in_ready  (f_in_ready),
		.in_data   ({sel_s, data_s}),
		.out_valid (f_out_valid),
		.out_ready (stage_free),
		.out_data  (f_out_data)
	);
	// Valid never waits on ready, so a sink that waits for valid cannot stall
	wire fifo_pop   = f_out_valid && stage_free;

	always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			HOST_DATA_LINES_OUT           <= HPHS_DATA_RST;
			HOST_DATA_LINES_OE_OUT        <= 1'b0;
			HOST_SERVICE_REQUEST_N_OUT    <= 1'b1;
			HOST_SERVICE_REQUEST_N_OE_OUT <= 1'b0;
			WR_VALID_OUT                  <= 1'b0;
			WR_DATA_OUT                   <= HPHS_DATA_RST;
			WR_REG_OUT                    <= '0;
			WR_DROP_OUT                   <= 1'b0;
			ACK_PULSE_OUT                 <= 1'b0;
			RD_DONE_OUT                   <= 1'b0;
			GPIO_IN_OUT                   <= '0;
			GPIO_DIR_OUT_OE               <= HPHS_GPIO_DIR_RST[HPHS_B_DIR];
			GPIO_STB_OUT_OE               <= HPHS_GPIO_DIR_RST[HPHS_B_STB];
			GPIO_ACK_OUT_OE               <= HPHS_GPIO_DIR_RST[HPHS_B_ACK];
		end else begin
			HOST_DATA_LINES_OUT    <= RD_DATA_IN;
			HOST_DATA_LINES_OE_OUT <= drive_rd;
			if (host_mode) begin
				HOST_SERVICE_REQUEST_N_OUT    <= 1'b0;
				HOST_SERVICE_REQUEST_N_OE_OUT <= req_act;
			end else begin
				HOST_SERVICE_REQUEST_N_OUT    <= GPIO_DATA_IN[HPHS_B_REQ];
				HOST_SERVICE_REQUEST_N_OE_OUT <= GPIO_DIR_IN[HPHS_B_REQ];
			end
			GPIO_DIR_OUT_OE <= !host_mode && GPIO_DIR_IN[HPHS_B_DIR];
			GPIO_STB_OUT_OE <= !host_mode && GPIO_DIR_IN[HPHS_B_STB];
			GPIO_ACK_OUT_OE <= !host_mode && GPIO_DIR_IN[HPHS_B_ACK];
			GPIO_IN_OUT     <= {ack_n_s, HOST_SERVICE_REQUEST_N_OUT, stb_n_s, dir_s};
			if (fifo_pop) begin
				WR_VALID_OUT <= 1'b1;
				{WR_REG_OUT, WR_DATA_OUT} <= f_out_data;
			end else if (WR_READY_IN) begin
				WR_VALID_OUT <= 1'b0;
			end
			WR_DROP_OUT   <= wr_take && !f_in_ready;
			ACK_PULSE_OUT <= ack_fall;
			RD_DONE_OUT   <= rd_done;
		end
	end

	AST_RD_DRIVE: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
		host_mode && !stb_n_s && dir_s |=> HOST_DATA_LINES_OE_OUT)
		else $error("Read strobe did not drive data lines");
	AST_WR_INPUT: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
		host_mode && !stb_n_s && !dir_s && !(req_act && !ack_n_s) |=> !HOST_DATA_LINES_OE_OUT)
		else $error("Data lines driven during host write");
	AST_WR_CAPTURE: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
		wr_take && f_in_ready |=> !$stable(u_fifo.wr_ptr))
		else $error("Write edge not captured");
	AST_IDLE_HIZ: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
		host_mode && stb_n_s && ack_n_s |=> !HOST_DATA_LINES_OE_OUT)
		else $error("Data lines driven with strobe idle");
	AST_REQ_OD: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
		host_mode ##1 host_mode |-> !HOST_SERVICE_REQUEST_N_OE_OUT || !HOST_SERVICE_REQUEST_N_OUT)
		else $error("Request pin drove high in host mode");
	AST_ACK_DRIVE: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
		req_act && !ack_n_s |=> HOST_DATA_LINES_OE_OUT)
		else $error("Acknowledge did not drive data lines");
	AST_GPIO_PP: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
		!host_mode && GPIO_DIR_IN[HPHS_B_REQ] |=> HOST_SERVICE_REQUEST_N_OE_OUT)
		else $error("Request pin not push-pull as general output");
	AST_GPIO_MODE: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
		host_mode |=> !GPIO_DIR_OUT_OE && !GPIO_STB_OUT_OE && !GPIO_ACK_OUT_OE)
		else $error("General output enabled in host mode");
	AST_SYNC: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
		$fell(HOST_ACKNOWLEDGE_N_IN) |-> !ack_fall)
		else $error("Acknowledge edge used before synchroniser");
	CV_READ:  cover property (@(posedge REF_CLK_IN) rd_done);
	CV_WRITE: cover property (@(posedge REF_CLK_IN) wr_take);
	CV_ACK:   cover property (@(posedge REF_CLK_IN) ack_fall && req_act);
	CV_FULL:  cover property (@(posedge REF_CLK_IN) wr_take && !f_in_ready);
endmodule // hphs_top

// ===== testbench/hphs_host.sv
// Host model: strobe, direction, acknowledge, select and data wire
`timescale 1ns/100ps
module hphs_host (
	input  wire logic       clk,
	input  wire logic       oe_in,
	input  wire logic [7:0] dev_in,
	output logic            dir_out,
	output logic            stb_n_out,
	output logic            ack_n_out,
	output logic [2:0]      sel_out,
	output logic [7:0]      wire_out
);
	logic [7:0] hd = 8'h00;
	logic [7:0] last = 8'h00;
	logic       hoe = 1'b0;
	initial {dir_out, stb_n_out, ack_n_out, sel_out} = 6'h18;
	// Released lines flip each cycle so a stale value never matches
	assign wire_out = oe_in ? dev_in : (hoe ? hd : ~last);
	always @(posedge clk) last <= wire_out;
	task automatic xfer(input logic rd, input logic [2:0] s, input logic [7:0] d,
		input int hold, output logic [7:0] q);
		@(posedge clk);
		dir_out <= rd;
		sel_out <= s;
		hd <= d;
		hoe <= !rd;
		@(posedge clk);
		stb_n_out <= 1'b0;
		repeat (hold) @(posedge clk);
		q = wire_out;
		stb_n_out <= 1'b1;
		repeat (3) @(posedge clk);
		hoe <= 1'b0;
	endtask
	task automatic ack(input int n, output logic o);
		@(posedge clk);
		ack_n_out <= 1'b0;
		repeat (n) @(posedge clk);
		o = oe_in;
		ack_n_out <= 1'b1;
	endtask
endmodule // hphs_host

// ===== testbench/hphs_top_tb.sv
// Self-checking bench for the host port pin handshake block
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
	$display("unexpected %s exp %0h got %0h", n, e, g); end end
module hphs_top_tb;
	logic       clk = 1'b0, rst_n = 1'b0, mode = 1'b1, sreq = 1'b0, rdy = 1'b1, o;
	logic [7:0] rdd = 8'h00, dq, h_d, d_out, wdat;
	logic [3:0] gdir = 4'h0, gdat = 4'h0, gin;
	logic       h_dir, h_stb, h_ack, d_oe, r_n, r_oe, wv, drop, ackp, oe0, oe1, oe3, rdone;
	logic [2:0] h_sel, wreg;
	logic [7:0] last_wr;
	int         err_count = 0, num_checks = 0, drops = 0, pops = 0, acks = 0, rds = 0;
	wire        dir_w = oe0 ? gdat[0] : h_dir;
	wire        stb_w = oe1 ? gdat[1] : h_stb;
	wire        ack_w = oe3 ? gdat[3] : h_ack;
	hphs_top i_dut (
		.REF_CLK_IN(clk), .RST_B_IN(rst_n), .HOST_PORT_SEL_IN(mode),
		.HOST_DIR_SELECT_IN(dir_w), .HOST_TRANSFER_STROBE_N_IN(stb_w),
		.HOST_ACKNOWLEDGE_N_IN(ack_w), .HOST_REG_SELECT_IN(h_sel),
		.HOST_DATA_LINES_IN(h_d), .HOST_DATA_LINES_OUT(d_out),
		.HOST_DATA_LINES_OE_OUT(d_oe), .HOST_SERVICE_REQUEST_N_OUT(r_n),
		.HOST_SERVICE_REQUEST_N_OE_OUT(r_oe), .RD_DATA_IN(rdd), .SERVICE_REQ_IN(sreq),
		.WR_VALID_OUT(wv), .WR_READY_IN(rdy), .WR_DATA_OUT(wdat), .WR_REG_OUT(wreg),
		.WR_DROP_OUT(drop), .ACK_PULSE_OUT(ackp), .RD_DONE_OUT(rdone), .GPIO_IN_OUT(gin),
		.GPIO_DIR_IN(gdir), .GPIO_DATA_IN(gdat), .GPIO_DIR_OUT_OE(oe0),
		.GPIO_STB_OUT_OE(oe1), .GPIO_ACK_OUT_OE(oe3)
	);
	hphs_host i_host (
		.clk(clk), .oe_in(d_oe), .dev_in(d_out), .dir_out(h_dir), .stb_n_out(h_stb),
		.ack_n_out(h_ack), .sel_out(h_sel), .wire_out(h_d)
	);
	initial forever #25 clk = ~clk;
	always @(posedge clk) begin
		if (drop) drops++;
		if (ackp) acks++;
		if (rdone) rds++;
		if (wv && rdy) pops++;
		if (wv && rdy) last_wr <= wdat;
	end
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic t_reset();
		repeat (6) @(posedge clk);
		`CHK("data_oe", 1'b0, d_oe)
		`CHK("pin_oe", 4'h0, {oe3, r_oe, oe1, oe0})
		// Open drain: a released request line reads high through its pull-up
		`CHK("req_n", 1'b1, r_oe ? r_n : 1'b1)
	endtask
	task automatic t_write();
		i_host.xfer(1'b0, 3'h5, 8'hA5, 3, dq);
		`CHK("wr_wire", 8'hA5, dq)
		for (int i = 0; i < 20 && wv !== 1'b1; i++) @(posedge clk);
		`CHK("wr_data", 8'hA5, wdat)
		`CHK("wr_reg", 3'h5, wreg)
	endtask
	task automatic t_read();
		rdd <= 8'h3C;
		rds = 0;
		i_host.xfer(1'b1, 3'h2, 8'h00, 6, dq);
		`CHK("rd_wire", 8'h3C, dq)
		repeat (2) @(posedge clk);
		`CHK("oe_idle", 1'b0, d_oe)
		`CHK("rd_done", 1, rds)
	endtask
	task automatic t_req();
		sreq <= 1'b1;
		acks = 0;
		repeat (4) @(posedge clk);
		`CHK("req", 2'b10, {r_oe, r_n})
		i_host.ack(6, o);
		`CHK("ack_oe", 1'b1, o)
		sreq <= 1'b0;
		repeat (5) @(posedge clk);
		`CHK("acks", 1, acks)
		`CHK("req_rel", 1'b0, r_oe)
	endtask
	task automatic t_fifo();
		rdy <= 1'b0;
		drops = 0;
		// Output stage plus buffer hold nine; the tenth write must be lost
		for (int i = 0; i < 10; i++) i_host.xfer(1'b0, i[2:0], 8'h10 + i[7:0], 2, dq);
		repeat (3) @(posedge clk);
		`CHK("drops", 1, drops)
		`CHK("held", 1'b1, wv)
		pops = 0;
		rdy <= 1'b1;
		repeat (30) @(posedge clk);
		`CHK("pops", 9, pops)
		`CHK("last", 8'h18, last_wr)
	endtask
	task automatic t_gpio();
		mode <= 1'b0;
		gdir <= 4'b1101;
		gdat <= 4'b0101;
		// Mode passes two stages, then driven pins pass two more back in
		repeat (8) @(posedge clk);
		`CHK("pin_oe", 4'b1101, {oe3, r_oe, oe1, oe0})
		`CHK("req_pp", 1'b1, r_n)
		`CHK("gpio_in", 3'b011, {gin[3], gin[1], gin[0]})
	endtask
	initial begin
		#1000000;
		err_count++;
		tally_and_finish();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_write();
		t_read();
		t_req();
		t_fifo();
		t_gpio();
		tally_and_finish();
	end
endmodule // hphs_top_tb
